// File: tbc_pkg.sv
// Purpose: constants and types shared by the time base divider block
// Assumes: one system clock, AHB-Lite register access, 32-bit bus words
// Notes: printed register offsets are indices; byte address is four times the index
//
// Overview of operation
// - The slow-base view register returns the eight taps 128 Hz (bit 0) to 1 Hz (bit 7), zero at reset.
// - Any write to the slow-base view register zeroes the whole counter and its taps; data is ignored.
// - A falling tap edge caused by that clearing write raises its interrupt like a counting edge.
// - After reset the slow counter starts at zero and advances on slow clock falling edges.
// - Falling edges of the 128 Hz, 32 Hz, 16 Hz and 2 Hz taps each raise their own interrupt.
// - The 32 kHz stage and the eight taps 128 Hz to 1 Hz are driven out for use by other peripherals.
// - The fast-divider select register resets to zero and holds divide_select in bits 3 to 0.
// - Divide_select value k selects a ratio of 1/(16-k), from 1/16 at zero to 1/1 at fifteen.
// - The fast clock divided by the selected ratio forms the fast base clock for timers and PWM.
// - The taps come from successive halving of the slow clock, 32 kHz at the top down to 1 Hz.

package tbc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [15:0] SLOW_TAP_VIEW_IDX = 16'hf00a;
  localparam logic [15:0] FAST_DIV_SEL_IDX = 16'hf00b;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'hf00c;
  localparam logic [15:0] IRQ_MASK_IDX = 16'hf00d;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 17;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int SLOW_CNT_W = 15;
  localparam int TAP_128HZ_BIT = 7;
  localparam int TAP_W = 8;
  localparam int DIV_SEL_W = 4;
  localparam int PERIOD_W = 5;
  localparam int IRQ_W = 4;
  localparam logic [PERIOD_W-1:0] DIV_BASE = 5'h10;
  localparam logic [7:0] TAP_VIEW_RST = 8'h00;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
  // tap positions that raise interrupts: 128 Hz, 32 Hz, 16 Hz, 2 Hz
  localparam int IRQ_TAP_0 = 0;
  localparam int IRQ_TAP_1 = 2;
  localparam int IRQ_TAP_2 = 3;
  localparam int IRQ_TAP_3 = 6;

  // ----------------------------------------------------------------
  // bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } bus_state_t;

endpackage : tbc_pkg

// File: fast_base_divider.sv
// Purpose: programmable 1/n divider producing the fast base clock pulse
// Assumes: fast_edge is a one-cycle pulse per fast clock rising edge
// Notes: ratio is taken at each period boundary

`timescale 1ns/10ps

module fast_base_divider (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic fast_edge, // one pulse per fast clock edge
  input wire logic [tbc_pkg::DIV_SEL_W-1:0] divide_select, // ratio select
  output logic fast_base_clock // one pulse per n fast clocks
);

  logic [tbc_pkg::PERIOD_W-1:0] period_reg;
  logic [tbc_pkg::PERIOD_W-1:0] count_reg;
  logic pulse_reg;
  logic period_end;

  // last count of the current period
  assign period_end = (count_reg == period_reg - 5'h01);

  // ----------------------------------------------------------------
  // ratio decode
  // ----------------------------------------------------------------
  function automatic logic [tbc_pkg::PERIOD_W-1:0] ratio_of(
    input logic [tbc_pkg::DIV_SEL_W-1:0] sel
  );
    ratio_of = tbc_pkg::DIV_BASE - {1'b0, sel};
  endfunction : ratio_of

  // ----------------------------------------------------------------
  // counting period
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      period_reg <= tbc_pkg::DIV_BASE;
      count_reg <= '0;
    end else if (fast_edge) begin
      if (period_end) begin
        count_reg <= '0;
        period_reg <= ratio_of(divide_select);
      end else begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= fast_edge && period_end;
    end
  end

  assign fast_base_clock = pulse_reg;

endmodule : fast_base_divider

// File: time_base_divider.sv
// Purpose: slow base counter with tap view, tap interrupts and fast divider
// Assumes: slow_clock and fast_clock are pins from other clock sources
// Notes: zero-wait AHB-Lite slave; registers sit at byte address 4 x index
//
// The AHB-Lite slave port was left to the implementer.

`timescale 1ns/10ps

module time_base_divider (
  input wire logic sys_clk, // system clock, 125 MHz
  input wire logic rst_n, // synchronous reset, active low
  // AHB-Lite slave
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  output logic [31:0] hrdata, // read data
  // clocks from outside
  input wire logic slow_clock, // slow clock pin
  input wire logic fast_clock, // fast clock pin
  // outputs to peripherals
  output logic tap_32khz, // top stage, synchronised slow clock
  output logic [7:0] slow_taps, // 128 Hz (bit 0) to 1 Hz (bit 7)
  output logic fast_base_clock, // fast base clock pulse
  output logic [3:0] time_base_irq, // per-tap interrupt request pulses
  output logic irq // level interrupt
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic slow_s1_reg;
  logic slow_s2_reg;
  logic slow_prev_reg;
  logic fast_s1_reg;
  logic fast_s2_reg;
  logic fast_prev_reg;
  logic slow_fall;
  logic fast_rise;

  logic [tbc_pkg::SLOW_CNT_W-1:0] slow_cnt_reg;
  logic [tbc_pkg::TAP_W-1:0] taps;
  logic [tbc_pkg::TAP_W-1:0] taps_prev_reg;
  logic [tbc_pkg::TAP_W-1:0] tap_fall;
  logic [tbc_pkg::IRQ_W-1:0] tap_events;
  logic [tbc_pkg::IRQ_W-1:0] tb_irq_reg;

  logic [tbc_pkg::DIV_SEL_W-1:0] div_sel_reg;
  logic [tbc_pkg::IRQ_W-1:0] irq_status_reg;
  logic [tbc_pkg::IRQ_W-1:0] irq_mask_reg;
  logic irq_reg;

  tbc_pkg::bus_state_t bus_state_reg;
  tbc_pkg::bus_state_t bus_state_next;
  logic addr_phase;
  logic wr_reg;
  logic [15:0] idx_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic data_wr;
  logic tap_clear;
  logic [tbc_pkg::IRQ_W-1:0] irq_clear;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // register index of a byte address, or all ones when out of range or misaligned
  function automatic logic [15:0] index_of(input logic [31:0] addr);
    if (addr[31:tbc_pkg::IDX_MSB+1] == '0 && addr[tbc_pkg::IDX_LSB-1:0] == '0) begin
      index_of = addr[tbc_pkg::IDX_MSB:tbc_pkg::IDX_LSB];
    end else begin
      index_of = 16'hffff;
    end
  endfunction : index_of

  // pad a narrow register into a bus word
  function automatic logic [31:0] word_of(input logic [7:0] value);
    word_of = {24'h000000, value};
  endfunction : word_of

  // sticky status after this cycle's clears and events; a new event wins over a clear
  function automatic logic [tbc_pkg::IRQ_W-1:0] status_after(
    input logic [tbc_pkg::IRQ_W-1:0] status,
    input logic [tbc_pkg::IRQ_W-1:0] clear,
    input logic [tbc_pkg::IRQ_W-1:0] events
  );
    status_after = (status & ~clear) | events;
  endfunction : status_after

  // data-phase write aimed at one register index
  function automatic logic write_hit(
    input logic write_phase,
    input logic [15:0] idx,
    input logic [15:0] target
  );
    write_hit = write_phase && (idx == target);
  endfunction : write_hit

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slow_s1_reg <= 1'b0;
      slow_s2_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else begin
      slow_s1_reg <= slow_clock;
      slow_s2_reg <= slow_s1_reg;
      slow_prev_reg <= slow_s2_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fast_s1_reg <= 1'b0;
      fast_s2_reg <= 1'b0;
      fast_prev_reg <= 1'b0;
    end else begin
      fast_s1_reg <= fast_clock;
      fast_s2_reg <= fast_s1_reg;
      fast_prev_reg <= fast_s2_reg;
    end
  end

  assign slow_fall = slow_prev_reg & ~slow_s2_reg;
  assign fast_rise = fast_s2_reg & ~fast_prev_reg;

  // ----------------------------------------------------------------
  // slow base counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slow_cnt_reg <= '0;
    end else if (tap_clear) begin
      slow_cnt_reg <= '0;
    end else if (slow_fall) begin
      slow_cnt_reg <= slow_cnt_reg + 15'h0001;
    end
  end

  // bit 0 is 16 kHz; bit 7 is 128 Hz when the slow clock is 32.768 kHz
  assign taps = slow_cnt_reg[tbc_pkg::SLOW_CNT_W-1:tbc_pkg::TAP_128HZ_BIT];

  assign tap_32khz = slow_s2_reg;
  assign slow_taps = taps;

  // ----------------------------------------------------------------
  // tap interrupts
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      taps_prev_reg <= '0;
    end else begin
      taps_prev_reg <= taps;
    end
  end

  // a clearing write also shows up here as a falling edge
  assign tap_fall = taps_prev_reg & ~taps;

  assign tap_events = {
    tap_fall[tbc_pkg::IRQ_TAP_3],
    tap_fall[tbc_pkg::IRQ_TAP_2],
    tap_fall[tbc_pkg::IRQ_TAP_1],
    tap_fall[tbc_pkg::IRQ_TAP_0]
  };

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tb_irq_reg <= '0;
    end else begin
      tb_irq_reg <= tap_events;
    end
  end

  assign time_base_irq = tb_irq_reg;

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= status_after(irq_status_reg, irq_clear, tap_events);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_after(irq_status_reg, irq_clear, tap_events) & irq_mask_reg);
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // fast base divider
  // ----------------------------------------------------------------
  fast_base_divider u_fast_base_divider (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fast_edge(fast_rise),
    .divide_select(div_sel_reg),
    .fast_base_clock(fast_base_clock)
  );

  // ----------------------------------------------------------------
  // bus slave: phases
  // ----------------------------------------------------------------
  assign addr_phase = hsel && htrans[1] && hready;

  always_comb begin
    bus_state_next = tbc_pkg::BUS_IDLE;
    case (bus_state_reg)
      tbc_pkg::BUS_IDLE: begin
        if (addr_phase) begin
          bus_state_next = tbc_pkg::BUS_DATA;
        end
      end
      tbc_pkg::BUS_DATA: begin
        if (addr_phase) begin
          bus_state_next = tbc_pkg::BUS_DATA;
        end
      end
      default: begin
        bus_state_next = tbc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bus_state_reg <= tbc_pkg::BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_reg <= 1'b0;
      idx_reg <= 16'hffff;
    end else if (addr_phase) begin
      wr_reg <= hwrite;
      idx_reg <= index_of(haddr);
    end
  end

  assign data_wr = (bus_state_reg == tbc_pkg::BUS_DATA) && wr_reg;
  assign tap_clear = write_hit(data_wr, idx_reg, tbc_pkg::SLOW_TAP_VIEW_IDX);
  assign irq_clear = write_hit(data_wr, idx_reg, tbc_pkg::IRQ_STATUS_IDX) ?
    hwdata[tbc_pkg::IRQ_W-1:0] : '0;

  // ----------------------------------------------------------------
  // bus slave: writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      div_sel_reg <= tbc_pkg::DIV_SEL_RST;
    end else if (write_hit(data_wr, idx_reg, tbc_pkg::FAST_DIV_SEL_IDX)) begin
      div_sel_reg <= hwdata[tbc_pkg::DIV_SEL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_mask_reg <= tbc_pkg::IRQ_MASK_RST;
    end else if (write_hit(data_wr, idx_reg, tbc_pkg::IRQ_MASK_IDX)) begin
      irq_mask_reg <= hwdata[tbc_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // bus slave: read data
  // ----------------------------------------------------------------
  // taps are captured in one edge at the address phase
  always_comb begin
    rdata_next = 32'h00000000;
    case (index_of(haddr))
      tbc_pkg::SLOW_TAP_VIEW_IDX: begin
        rdata_next = word_of(taps);
      end
      tbc_pkg::FAST_DIV_SEL_IDX: begin
        rdata_next = word_of({4'h0, div_sel_reg});
      end
      tbc_pkg::IRQ_STATUS_IDX: begin
        rdata_next = word_of({4'h0, irq_status_reg});
      end
      tbc_pkg::IRQ_MASK_IDX: begin
        rdata_next = word_of({4'h0, irq_mask_reg});
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_reg <= word_of(tbc_pkg::TAP_VIEW_RST);
    end else if (addr_phase && !hwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule : time_base_divider

// File: time_base_divider_chk.sv
// Purpose: port checks for the time base divider
// Assumes: single slave, hready fed from hreadyout
// Notes: irq pulse latency taken as one or two cycles
`timescale 1ns/10ps
module time_base_divider_chk (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // reset
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic [31:0] hrdata, // read data
  input wire logic [7:0] slow_taps, // taps
  input wire logic fast_base_clock, // divider pulse
  input wire logic [3:0] time_base_irq // tap pulses
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  localparam logic [31:0] view_addr = {14'h0, tbc_pkg::SLOW_TAP_VIEW_IDX, 2'b00};
  // ---------------------------------------------
  // sequences
  // ---------------------------------------------
  sequence view_req;
    hsel && htrans[1] && hready && haddr == view_addr;
  endsequence
  sequence view_rd;
    view_req ##0 !hwrite;
  endsequence
  sequence view_wr;
    view_req ##0 hwrite;
  endsequence
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  a_bus_ready_okay: assert property (hreadyout && !hresp && hrdata[31:8] == 24'h0)
    else $error("bus answer not ready, okay or clean");
  a_read_snapshot: assert property (view_rd |=> hrdata[7:0] == $past(slow_taps))
    else $error("tap view read differs from taps");
  a_write_clears: assert property (view_wr |-> ##2 slow_taps == 8'h00)
    else $error("tap view write did not clear taps");
  a_tap_binary: assert property ($changed(slow_taps) && slow_taps != 8'h00 |->
    slow_taps == $past(slow_taps) + 8'h01) else $error("taps did not count by one");
  a_fall_128hz: assert property ($fell(slow_taps[0]) |-> ##[1:2] time_base_irq[0])
    else $error("128 Hz fall without interrupt");
  a_fall_2hz: assert property ($fell(slow_taps[6]) |-> ##[1:2] time_base_irq[3])
    else $error("2 Hz fall without interrupt");
  a_cause_32hz: assert property (time_base_irq[1] |-> !slow_taps[2] &&
    ($past(slow_taps[2], 2) || $past(slow_taps[2], 3))) else $error("32 Hz pulse unprompted");
  a_pulse_single: assert property (|time_base_irq |=> time_base_irq == 4'h0)
    else $error("tap interrupt longer than one cycle");
  a_fast_gap: assert property (fast_base_clock |=> !fast_base_clock [*3])
    else $error("fast base pulses too close");
endmodule : time_base_divider_chk
bind time_base_divider time_base_divider_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .slow_taps(slow_taps), .fast_base_clock(fast_base_clock),
  .time_base_irq(time_base_irq)
);

// File: clock_partner.sv
// Purpose: slow and fast clock sources feeding the block
// Assumes: slow clock may be stopped, fast clock runs free
// Notes: counts slow falling edges for the bench
`timescale 1ns/10ps
module clock_partner (
  input wire logic slow_run, // slow clock enable
  output logic slow_clock, // slow clock
  output logic fast_clock, // fast clock
  output int slow_falls // slow falling edges so far
);
  initial begin
    slow_clock = 1'b1;
    fast_clock = 1'b0;
    slow_falls = 0;
  end
  always #21 fast_clock = ~fast_clock;
  // stopped clock rests at its last level
  always begin
    #32;
    if (slow_run) begin
      slow_clock = ~slow_clock;
      if (!slow_clock) slow_falls++;
    end
  end
endmodule : clock_partner

// File: time_base_divider_test.sv
// Purpose: self-checking bench for the time base divider
// Assumes: 8 ns clock, slow falling edge every 64 ns, fast period 42 ns
// Notes: fast periods rounded to whole fast clocks
`timescale 1ns/10ps
module time_base_divider_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic slow_run = 1'b0;
  logic hreadyout, hresp, slow_clock, fast_clock, tap_32khz, fast_base_clock, irq;
  logic [31:0] hrdata;
  logic [7:0] slow_taps;
  logic [3:0] time_base_irq;
  int slow_falls;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [31:0] view_a = {14'h0, tbc_pkg::SLOW_TAP_VIEW_IDX, 2'b00};
  localparam logic [31:0] div_a = {14'h0, tbc_pkg::FAST_DIV_SEL_IDX, 2'b00};
  localparam logic [31:0] stat_a = {14'h0, tbc_pkg::IRQ_STATUS_IDX, 2'b00};
  localparam logic [31:0] mask_a = {14'h0, tbc_pkg::IRQ_MASK_IDX, 2'b00};
  always #4 sys_clk = ~sys_clk;
  time_base_divider u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .slow_clock(slow_clock),
    .fast_clock(fast_clock), .tap_32khz(tap_32khz), .slow_taps(slow_taps),
    .fast_base_clock(fast_base_clock), .time_base_irq(time_base_irq), .irq(irq)
  );
  clock_partner u_clk (.slow_run(slow_run), .slow_clock(slow_clock),
    .fast_clock(fast_clock), .slow_falls(slow_falls));
  // ---------------------------------------------
  // common tasks
  // ---------------------------------------------
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    q = hrdata;
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [31:0] a, input logic [31:0] exp, input string name);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(name, exp, q);
  endtask : rd
  task settle_irq(input logic exp);
    repeat (2) @(posedge sys_clk);
    chk("irq", {31'h0, exp}, {31'h0, irq});
  endtask : settle_irq
  task wait_pulse(output realtime t);
    while (fast_base_clock !== 1'b1) @(posedge sys_clk);
    t = $realtime;
    @(posedge sys_clk);
  endtask : wait_pulse
  task wait_tbi(input int b, input int exp);
    @(posedge sys_clk);
    while (time_base_irq[b] !== 1'b1) @(posedge sys_clk);
    chk("slow edges at tap interrupt", 32'(exp), 32'(slow_falls));
  endtask : wait_tbi
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task check_reset;
    rd(view_a, 32'h0, "tap view");
    rd(div_a, 32'h0, "divide_select");
    rd(stat_a, 32'h0, "irq status");
    rd(mask_a, 32'h0, "irq mask");
    chk("tap_32khz", {31'h0, slow_clock}, {31'h0, tap_32khz});
    wr(32'h0003c038, 32'hff);
    rd(32'h0003c038, 32'h0, "unmapped");
  endtask : check_reset
  task check_divider;
    realtime t0, t1;
    for (int k = 0; k < 16; k++) begin
      wr(div_a, 32'(k));
      rd(div_a, 32'(k), "divide_select");
      wait_pulse(t0);
      wait_pulse(t0);
      wait_pulse(t1);
      chk("fast period", 32'(16 - k), 32'($rtoi((t1 - t0) / 42.0 + 0.5)));
    end
  endtask : check_divider
  task check_slow;
    wr(view_a, 32'hff);
    rd(view_a, 32'h0, "tap view");
    slow_run <= 1'b1;
    wait_tbi(0, 256);
    wait_tbi(1, 1024);
    wait_tbi(2, 2048);
    while (slow_falls < 8192) @(posedge sys_clk);
    slow_run <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(view_a, 32'h40, "tap view");
    rd(view_a, 32'h40, "tap view again");
    chk("slow taps", 32'h40, {24'h0, slow_taps});
    chk("tap_32khz", {31'h0, slow_clock}, {31'h0, tap_32khz});
  endtask : check_slow
  task check_irq;
    rd(stat_a, 32'h7, "irq status");
    settle_irq(1'b0);
    wr(mask_a, 32'h1);
    settle_irq(1'b1);
    wr(stat_a, 32'h7);
    rd(stat_a, 32'h0, "irq status");
    settle_irq(1'b0);
    wr(mask_a, 32'h8);
    wr(view_a, 32'ha5);
    wait_tbi(3, 8192);
    rd(view_a, 32'h0, "tap view");
    rd(stat_a, 32'h8, "irq status");
    settle_irq(1'b1);
    wr(stat_a, 32'h8);
    settle_irq(1'b0);
  endtask : check_irq
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check_reset();
    check_divider();
    check_slow();
    check_irq();
    give_verdict();
  end
endmodule : time_base_divider_test
